// file: core/ddbl_consts.svh
// How it works
// - code sent as two byte writes
// - upper nibble on low four bus lines
// - auto mode needs four writes
// - strobed mode: four writes, one strobe
// - byte select low lower, high upper
// - channel select low first channel
`ifndef DDBL_CONSTS_SVH
`define DDBL_CONSTS_SVH
// ----------------------------------------
// register map of the controller
// ----------------------------------------
`define DDBL_ADDR_W 4
`define DDBL_REG_CTRL 4'h0
`define DDBL_REG_CODE_A 4'h4
`define DDBL_REG_CODE_B 4'h8
`define DDBL_REG_STATUS 4'hC
`define DDBL_CTRL_GO_BIT 0
`define DDBL_CTRL_STROBED_BIT 1
`define DDBL_CTRL_RESET_BIT 2
`define DDBL_CTRL_HIFIRST_BIT 3
`define DDBL_CODE_W 12
`define DDBL_CODE_MAX 12'hFFF
// ----------------------------------------
// pin timing, in ns and in cycles
// ----------------------------------------
`define DDBL_CLK_NS 10
`define DDBL_SETUP_NS 40
`define DDBL_PULSE_NS 60
`define DDBL_HOLD_NS 20
`define DDBL_RESET_NS 100
`define DDBL_CYC(ns) (((ns) + `DDBL_CLK_NS - 1) / `DDBL_CLK_NS)
`define DDBL_CNT_W 4
`endif

// file: core/ddbl_pkg.sv
package ddbl_pkg;
    typedef enum logic [3:0] {
        DDBL_IDLE = 4'b0000,
        DDBL_RST_LOW = 4'b0001,
        DDBL_SETUP = 4'b0010,
        DDBL_PULSE = 4'b0011,
        DDBL_HOLD = 4'b0100,
        DDBL_XFER = 4'b0101,
        DDBL_XFER_HOLD = 4'b0110,
        DDBL_NEXT = 4'b0111
    } ddbl_state_t;
    typedef struct packed {
        logic chan;
        logic upper;
        logic [7:0] data;
    } ddbl_byte_t;
endpackage

// file: core/ddbl_pin_if.sv
`timescale 1ns/1ps
interface ddbl_pin_if;
    logic [7:0] bus;
    logic chan_sel;
    logic byte_sel;
    logic write_n;
    logic transfer_strobe_n;
    logic dev_reset_n;
    modport drv (output bus, chan_sel, byte_sel, write_n, transfer_strobe_n, dev_reset_n);
    modport mon (input bus, chan_sel, byte_sel, write_n, transfer_strobe_n, dev_reset_n);
endinterface

// file: core/ddbl_pin_drv.sv
`timescale 1ns/1ps
`include "ddbl_consts.svh"
module ddbl_pin_drv
    import ddbl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // pin control from sequencer
    input wire logic [7:0] bus_i,
    input wire logic chan_i,
    input wire logic byte_i,
    input wire logic write_n_i,
    input wire logic strobe_n_i,
    input wire logic dev_reset_n_i,
    // pins
    ddbl_pin_if.drv pins
);
    // pins stay inactive and device held in reset from reset onward
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins.bus <= 8'h00;
            pins.chan_sel <= 1'b0;
            pins.byte_sel <= 1'b0;
            pins.write_n <= 1'b1;
            pins.transfer_strobe_n <= 1'b1;
            pins.dev_reset_n <= 1'b0;
        end else begin
            pins.bus <= bus_i;
            pins.chan_sel <= chan_i;
            pins.byte_sel <= byte_i;
            pins.write_n <= write_n_i;
            pins.transfer_strobe_n <= strobe_n_i;
            pins.dev_reset_n <= dev_reset_n_i;
        end
    end
endmodule // ddbl_pin_drv

// file: core/ddbl_avs.sv
`timescale 1ns/1ps
`include "ddbl_consts.svh"
module ddbl_avs
    import ddbl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // avalon slave
    input wire logic [`DDBL_ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // register contents
    output logic [3:0] ctrl_o,
    output logic go_o,
    output logic [11:0] code_a_o,
    output logic [11:0] code_b_o,
    input wire logic busy_i,
    input wire logic [3:0] state_i
);
    logic wait_q;
    logic [3:0] ctrl_q;
    logic go_q;
    logic [11:0] code_a_q;
    logic [11:0] code_b_q;
    logic [31:0] readdata_q;
    logic take;
    logic commit;
    // waitrequest idles high so it comes from a flop; one wait cycle per access
    assign take = (read_i || write_i) && wait_q;
    // writes land only at the edge where waitrequest is seen low
    assign commit = write_i && !wait_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !take;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= 4'h0;
            code_a_q <= 12'h000;
            code_b_q <= 12'h000;
        end else if (commit) begin
            if (address_i == `DDBL_REG_CTRL) begin
                ctrl_q <= {writedata_i[3:1], 1'b0};
            end else if (address_i == `DDBL_REG_CODE_A) begin
                code_a_q <= writedata_i[11:0];
            end else if (address_i == `DDBL_REG_CODE_B) begin
                code_b_q <= writedata_i[11:0];
            end
        end
    end
    // go is write-only; a go written while busy is ignored, other ctrl and code writes still land
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            go_q <= 1'b0;
        end else begin
            go_q <= commit && !busy_i && (address_i == `DDBL_REG_CTRL)
                && writedata_i[`DDBL_CTRL_GO_BIT];
        end
    end

    // read data taken in the wait cycle, stands when waitrequest drops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            readdata_q <= 32'h0000_0000;
        end else if (take && read_i) begin
            if (address_i == `DDBL_REG_CTRL) begin
                readdata_q <= {28'h0000000, ctrl_q};
            end else if (address_i == `DDBL_REG_CODE_A) begin
                readdata_q <= {20'h00000, code_a_q};
            end else if (address_i == `DDBL_REG_CODE_B) begin
                readdata_q <= {20'h00000, code_b_q};
            end else if (address_i == `DDBL_REG_STATUS) begin
                readdata_q <= {27'h0, state_i, busy_i};
            end else begin
                readdata_q <= 32'h0000_0000;
            end
        end
    end

    assign readdata_o = readdata_q;
    assign waitrequest_o = wait_q;
    assign ctrl_o = ctrl_q;
    assign go_o = go_q;
    assign code_a_o = code_a_q;
    assign code_b_o = code_b_q;
endmodule // ddbl_avs

// file: core/ddbl_ctrl.sv
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ddbl_consts.svh"
module ddbl_ctrl
    import ddbl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // avalon-mm slave
    input wire logic [`DDBL_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // device pins
    output logic [7:0] dac_bus_o,
    output logic dac_chan_sel_o,
    output logic dac_byte_sel_o,
    output logic dac_write_n_o,
    output logic transfer_strobe_n_o,
    output logic dac_reset_n_o,
    // status
    output logic busy_o
);
    localparam logic [`DDBL_CNT_W-1:0] SETUP_C = `DDBL_CNT_W'(`DDBL_CYC(`DDBL_SETUP_NS));
    localparam logic [`DDBL_CNT_W-1:0] PULSE_C = `DDBL_CNT_W'(`DDBL_CYC(`DDBL_PULSE_NS));
    localparam logic [`DDBL_CNT_W-1:0] HOLD_C = `DDBL_CNT_W'(`DDBL_CYC(`DDBL_HOLD_NS));
    localparam logic [`DDBL_CNT_W-1:0] RESET_C = `DDBL_CNT_W'(`DDBL_CYC(`DDBL_RESET_NS));

    ddbl_pin_if pins();
    logic [3:0] ctrl_q;
    logic go_pulse;
    logic [11:0] code_a_q;
    logic [11:0] code_b_q;
    ddbl_state_t state_q;
    logic [`DDBL_CNT_W-1:0] cnt_q;
    logic [1:0] idx_q;
    logic strobed_q;
    logic hifirst_q;
    logic [7:0] bus_d;
    logic chan_d;
    logic byte_d;
    logic upper_now;
    logic busy_q;

    ddbl_avs u_avs (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .address_i(avs_address_i),
        .read_i(avs_read_i),
        .write_i(avs_write_i),
        .writedata_i(avs_writedata_i),
        .readdata_o(avs_readdata_o),
        .waitrequest_o(avs_waitrequest_o),
        .ctrl_o(ctrl_q),
        .go_o(go_pulse),
        .code_a_o(code_a_q),
        .code_b_o(code_b_q),
        .busy_i(busy_q),
        .state_i(state_q)
    );

    // ----------------------------------------
    // byte selection
    // ----------------------------------------
    // two bytes per code, order chosen
    assign upper_now = idx_q[0] ^ hifirst_q;
    assign chan_d = idx_q[1];
    assign byte_d = upper_now;
    always_comb begin
        bus_d = 8'h00;
        if (upper_now) begin
            bus_d = {4'h0, (idx_q[1] ? code_b_q[11:8] : code_a_q[11:8])};
        end else begin
            bus_d = idx_q[1] ? code_b_q[7:0] : code_a_q[7:0];
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= DDBL_RST_LOW;
            cnt_q <= RESET_C;
            idx_q <= 2'b00;
            strobed_q <= 1'b0;
            hifirst_q <= 1'b0;
        end else begin
            case (state_q)
                DDBL_IDLE: begin
                    if (ctrl_q[`DDBL_CTRL_RESET_BIT]) begin
                        state_q <= DDBL_RST_LOW;
                        cnt_q <= RESET_C;
                    end else if (go_pulse) begin
                        state_q <= DDBL_SETUP;
                        cnt_q <= SETUP_C;
                        idx_q <= 2'b00;
                        strobed_q <= ctrl_q[`DDBL_CTRL_STROBED_BIT];
                        hifirst_q <= ctrl_q[`DDBL_CTRL_HIFIRST_BIT];
                    end
                end
                DDBL_RST_LOW: begin
                    if (cnt_q != 0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (!ctrl_q[`DDBL_CTRL_RESET_BIT]) begin
                        state_q <= DDBL_IDLE;
                    end
                end
                DDBL_SETUP: begin
                    if (cnt_q != 0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= DDBL_PULSE;
                        cnt_q <= PULSE_C;
                    end
                end
                DDBL_PULSE: begin
                    if (cnt_q != 0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= DDBL_HOLD;
                        cnt_q <= HOLD_C;
                    end
                end
                DDBL_HOLD: begin
                    if (cnt_q != 0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= DDBL_NEXT;
                    end
                end
                DDBL_NEXT: begin
                    if (idx_q != 2'b11) begin
                        idx_q <= idx_q + 2'b01;
                        state_q <= DDBL_SETUP;
                        cnt_q <= SETUP_C;
                    end else if (strobed_q) begin
                        state_q <= DDBL_XFER;
                        cnt_q <= PULSE_C;
                    end else begin
                        state_q <= DDBL_IDLE;
                    end
                end
                DDBL_XFER: begin
                    if (cnt_q != 0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= DDBL_XFER_HOLD;
                        cnt_q <= HOLD_C;
                    end
                end
                DDBL_XFER_HOLD: begin
                    if (cnt_q != 0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= DDBL_IDLE;
                    end
                end
                default: begin
                    state_q <= DDBL_IDLE;
                end
            endcase
        end
    end

    // strobe held low during the second byte write of each code in auto mode so that byte passes through
    logic write_n_d;
    logic strobe_n_d;
    logic dev_rst_n_d;
    always_comb begin
        write_n_d = (state_q != DDBL_PULSE);
        strobe_n_d = !(state_q == DDBL_XFER ||
            (!strobed_q && state_q == DDBL_PULSE && upper_now != hifirst_q));
        dev_rst_n_d = (state_q != DDBL_RST_LOW);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_q <= 1'b1;
        end else begin
            busy_q <= (state_q != DDBL_IDLE) || go_pulse;
        end
    end

    ddbl_pin_drv u_drv (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .bus_i(bus_d),
        .chan_i(chan_d),
        .byte_i(byte_d),
        .write_n_i(write_n_d),
        .strobe_n_i(strobe_n_d),
        .dev_reset_n_i(dev_rst_n_d),
        .pins(pins)
    );

    assign dac_bus_o = pins.bus;
    assign dac_chan_sel_o = pins.chan_sel;
    assign dac_byte_sel_o = pins.byte_sel;
    assign dac_write_n_o = pins.write_n;
    assign transfer_strobe_n_o = pins.transfer_strobe_n;
    assign dac_reset_n_o = pins.dev_reset_n;
    assign busy_o = busy_q;
endmodule // ddbl_ctrl

// file: verif/ddbl_ctrl_sva.sv
`timescale 1ns/1ps
`include "ddbl_consts.svh"
module ddbl_ctrl_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // avalon
    input wire logic [`DDBL_ADDR_W-1:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic avs_waitrequest_o,
    // device pins
    input wire logic [7:0] dac_bus_o,
    input wire logic dac_chan_sel_o,
    input wire logic dac_byte_sel_o,
    input wire logic dac_write_n_o,
    input wire logic transfer_strobe_n_o,
    input wire logic dac_reset_n_o,
    input wire logic busy_o
);
    logic wn_q;
    logic last_byte_q;
    logic strobed_q;
    logic [1:0] idx_q;
    logic wr_fall;
    assign wr_fall = wn_q & ~dac_write_n_o;
    // byte index within one sequence
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wn_q <= 1'b1;
            last_byte_q <= 1'b0;
            idx_q <= 2'h0;
        end else begin
            wn_q <= dac_write_n_o;
            if (wr_fall) last_byte_q <= dac_byte_sel_o;
            if (!busy_o) idx_q <= 2'h0;
            else if (wr_fall) idx_q <= idx_q + 2'h1;
        end
    end
    // mode taken from the accepted go write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strobed_q <= 1'b0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == `DDBL_REG_CTRL
                     && avs_writedata_i[`DDBL_CTRL_GO_BIT]) begin
            strobed_q <= avs_writedata_i[`DDBL_CTRL_STROBED_BIT];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_NIBBLE_LOW_LINES: assert property (
        !dac_write_n_o && dac_byte_sel_o |-> dac_bus_o[7:4] == 4'h0)
        else $error("upper nibble drives top bus lines");
    AST_WRITE_STEADY: assert property (
        !dac_write_n_o && !wn_q |-> $stable(dac_bus_o) && $stable(dac_byte_sel_o))
        else $error("bus or byte select moved during write");
    AST_SETUP_STEADY: assert property (
        wr_fall |-> $past(dac_chan_sel_o, 2) == dac_chan_sel_o && $past(dac_bus_o, 2) == dac_bus_o)
        else $error("write began without setup");
    AST_PAIR_BYTES: assert property (
        wr_fall && idx_q[0] |-> dac_byte_sel_o != last_byte_q)
        else $error("second byte repeats first half");
    AST_CHAN_ORDER: assert property (
        wr_fall |-> dac_chan_sel_o == idx_q[1])
        else $error("channel order wrong");
    AST_AUTO_SECOND: assert property (
        !strobed_q && $fell(transfer_strobe_n_o) |-> wr_fall && idx_q[0])
        else $error("auto transfer not on second byte");
    AST_STROBED_ALONE: assert property (
        strobed_q && !transfer_strobe_n_o |-> dac_write_n_o && idx_q == 2'h0)
        else $error("strobed transfer overlaps writes");
    AST_RESET_QUIET: assert property (
        !dac_reset_n_o |-> dac_write_n_o && transfer_strobe_n_o)
        else $error("strobe active during device reset");
    cover property (wr_fall && idx_q == 2'h3);
    cover property (strobed_q && $fell(transfer_strobe_n_o));
    cover property (!strobed_q && $fell(transfer_strobe_n_o));
    cover property ($rose(dac_reset_n_o));
endmodule // ddbl_ctrl_sva
bind ddbl_ctrl ddbl_ctrl_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
    .dac_bus_o(dac_bus_o), .dac_chan_sel_o(dac_chan_sel_o), .dac_byte_sel_o(dac_byte_sel_o),
    .dac_write_n_o(dac_write_n_o), .transfer_strobe_n_o(transfer_strobe_n_o),
    .dac_reset_n_o(dac_reset_n_o), .busy_o(busy_o));

// file: verif/ddbl_dev_model.sv
`timescale 1ns/1ps
module ddbl_dev_model (
    // device pins
    input wire logic [7:0] bus_i,
    input wire logic chan_sel_i,
    input wire logic byte_sel_i,
    input wire logic write_n_i,
    input wire logic strobe_n_i,
    input wire logic reset_n_i,
    // converter codes
    output logic [11:0] code_a_o,
    output logic [11:0] code_b_o
);
    logic [7:0] lo_a;
    logic [7:0] lo_b;
    logic [3:0] hi_a;
    logic [3:0] hi_b;
    always_latch begin
        if (!reset_n_i) begin
            lo_a <= 8'h00;
            lo_b <= 8'h00;
            hi_a <= 4'h0;
            hi_b <= 4'h0;
        end else if (!write_n_i) begin
            if (!chan_sel_i && !byte_sel_i) lo_a <= bus_i;
            if (!chan_sel_i && byte_sel_i) hi_a <= bus_i[3:0];
            if (chan_sel_i && !byte_sel_i) lo_b <= bus_i;
            if (chan_sel_i && byte_sel_i) hi_b <= bus_i[3:0];
        end
    end
    always_latch begin
        if (!reset_n_i) begin
            code_a_o <= 12'h000;
            code_b_o <= 12'h000;
        end else if (!strobe_n_i) begin
            code_a_o <= {hi_a, lo_a};
            code_b_o <= {hi_b, lo_b};
        end
    end
endmodule // ddbl_dev_model

// file: verif/ddbl_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "ddbl_consts.svh"
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH %0t %s", $time, m); end end
module ddbl_ctrl_tb_top
    import ddbl_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wait_req;
    logic [7:0] bus;
    logic chan, bsel, wn, sn, drst_n, busy;
    logic [11:0] code_a, code_b;
    logic wn_q = 1'b1;
    logic sn_q = 1'b1;
    int wr_cnt = 0;
    int xfer_cnt = 0;
    int err_count = 0;
    int samples_checked = 0;
    always #5 clk_i = ~clk_i;
    ddbl_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_req), .dac_bus_o(bus), .dac_chan_sel_o(chan),
        .dac_byte_sel_o(bsel), .dac_write_n_o(wn), .transfer_strobe_n_o(sn),
        .dac_reset_n_o(drst_n), .busy_o(busy));
    ddbl_dev_model u_dev (.bus_i(bus), .chan_sel_i(chan), .byte_sel_i(bsel), .write_n_i(wn),
        .strobe_n_i(sn), .reset_n_i(drst_n), .code_a_o(code_a), .code_b_o(code_b));
    // counts byte writes and transfer strobes
    always @(posedge clk_i) begin
        wn_q <= wn;
        sn_q <= sn;
        if (wn_q && !wn) wr_cnt++;
        if (sn_q && !sn) xfer_cnt++;
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------
    // avalon master, request held until waitrequest low
    // ----------------------------------------
    task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (wait_req === 1'b0) break;
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n == 50) begin err_count++; end_sim(); end
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        for (n = 0; n < 300; n++) begin
            avs(1'b0, `DDBL_REG_STATUS, 32'h0, s);
            if (s[0] === 1'b0) break;
        end
        if (n == 300) begin err_count++; end_sim(); end
    endtask
    task automatic run_seq(input logic [31:0] c, input logic [11:0] a, input logic [11:0] b);
        logic [31:0] q;
        avs(1'b1, `DDBL_REG_CODE_A, {20'h0, a}, q);
        avs(1'b1, `DDBL_REG_CODE_B, {20'h0, b}, q);
        wr_cnt = 0;
        xfer_cnt = 0;
        avs(1'b1, `DDBL_REG_CTRL, c, q);
    endtask
    task automatic wait_drst(input logic lvl);
        int n;
        for (n = 0; n < 100 && drst_n !== lvl; n++) @(posedge clk_i);
        if (n == 100) begin err_count++; end_sim(); end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_auto();
        logic [31:0] q;
        run_seq(32'h1, 12'hABC, 12'h5F3);
        wait_idle();
        `CHK(code_a, 12'hABC, "auto code a")
        `CHK(code_b, 12'h5F3, "auto code b")
        `CHK(wr_cnt, 4, "auto write count")
        `CHK(xfer_cnt, 2, "auto transfer count")
        `CHK(busy, 1'b0, "idle after auto")
        avs(1'b1, 4'h2, 32'hFFF, q);
        avs(1'b0, 4'h2, 32'h0, q);
        `CHK(q, 32'h0, "unmapped read")
        avs(1'b0, `DDBL_REG_CODE_A, 32'h0, q);
        `CHK(q[11:0], 12'hABC, "code a readback")
    endtask
    task automatic sc_strobed();
        int n;
        run_seq(32'h3, 12'hFFF, 12'h000);
        for (n = 0; n < 400 && wr_cnt < 4; n++) @(posedge clk_i);
        if (n == 400) begin err_count++; end_sim(); end
        `CHK(code_a, 12'hABC, "held before strobe")
        `CHK(code_b, 12'h5F3, "held b before strobe")
        `CHK(busy, 1'b1, "busy until strobe")
        wait_idle();
        `CHK(code_a, 12'hFFF, "strobed full scale")
        `CHK(code_b, 12'h000, "strobed zero")
        `CHK(xfer_cnt, 1, "one strobe")
    endtask
    task automatic sc_hifirst();
        run_seq(32'h9, 12'h123, 12'h800);
        wait_idle();
        `CHK(code_a, 12'h123, "upper first a")
        `CHK(code_b, 12'h800, "upper first b")
    endtask
    task automatic sc_devreset();
        logic [31:0] q;
        avs(1'b1, `DDBL_REG_CTRL, 32'h4, q);
        wait_drst(1'b0);
        `CHK(code_a, 12'h000, "held reset a")
        `CHK(code_b, 12'h000, "held reset b")
        avs(1'b1, `DDBL_REG_CTRL, 32'h0, q);
        wait_drst(1'b1);
        `CHK(code_a, 12'h000, "zero after release")
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wait_idle();
        `CHK(code_a, 12'h000, "power up zero")
        sc_auto();
        sc_strobed();
        sc_hifirst();
        sc_devreset();
        sc_auto();
        end_sim();
    end
endmodule // ddbl_ctrl_tb_top
